// ==== hw/cg_decode.sv ====
`timescale 1ns/1ps
module cg_decode (
  // Code-group in
  input  wire logic [4:0] cg,
  // Nibble out
  output logic      [3:0] nib,
  output logic            valid
);
  import rx_pcs_pkg::*;

  // ****************************************
  // Fixed 5B to 4B table
  // ****************************************
  always_comb begin
    valid = 1'b1;
    case (cg)
      5'h1E: nib = 4'h0;
      5'h09: nib = 4'h1;
      5'h14: nib = 4'h2;
      5'h15: nib = 4'h3;
      5'h0A: nib = 4'h4;
      5'h0B: nib = 4'h5;
      5'h0E: nib = 4'h6;
      5'h0F: nib = 4'h7;
      5'h12: nib = 4'h8;
      5'h13: nib = 4'h9;
      5'h16: nib = 4'hA;
      5'h17: nib = 4'hB;
      5'h1A: nib = 4'hC;
      5'h1B: nib = 4'hD;
      5'h1C: nib = 4'hE;
      5'h1D: nib = 4'hF;
      default: begin
        nib   = NIB_BADSSD;
        valid = 1'b0;
      end
    endcase
  end

endmodule : cg_decode

// ==== hw/rx_pcs_decode.sv ====
`timescale 1ns/1ps
// Operation
// - Descrambler XORs each received bit with a regenerated scrambler sequence.
// - Lock after twelve consecutive descrambled IDLE groups, then output unaligned bits.
// - On lock a 722 us hold countdown runs while idles are checked.
// - 58 idle bit times before expiry reload the hold countdown.
// - Hold expiry without enough idles drops lock and restarts acquisition.
// - Aligner input is descrambler output, or NRZ bits when bypassed.
// - Alignment fixed on detection of the J then K code-group pair.
// - Each aligned code-group becomes a nibble through a fixed table.
// - J/K after idles is replaced by a single preamble nibble 0101.
// - Packet decoding ends on T/R pair or two IDLE groups.
// - Link up only after signal detect held valid for 395 us.
// - Link pulses never raise signal detect; front end guarantees this.
// - Idle to non-idle other than J flags a bad start delimiter; J without K is not flagged.
// - Bad start delimiter drives error and nibble 1110 until two idles.
// - Each bad start delimiter adds one to false carrier count, saturating at CNT_MAX.
// - After bad start delimiter, error and carrier drop after two idles.
// - Serial-to-parallel delivers 5-bit symbols to the receive machine.
// - Control code-groups other than T inside packet data decode as invalid with error.
// - Sequence comes from an 11-bit LFSR, fed from the line until lock, closed-loop after.
module rx_pcs_decode (
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  // Front end
  input  wire logic                         rx_nrzi,
  input  wire logic                         rx_bit_en,
  input  wire logic                         signal_detect,
  input  wire logic                         descr_bypass,
  // MAC side
  output rx_pcs_pkg::mii_rx_t               mii_rx,
  output logic                              mii_rx_en,
  // Status
  output logic                              descr_locked,
  output logic                              link_up,
  output logic [rx_pcs_pkg::CNT_W-1:0]      false_carrier_event_counter
);
  import rx_pcs_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] nrzi_s_q;
  logic [2:0] sd_s_q;
  logic       nrzi_f_q;
  logic       sd_f_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      nrzi_s_q <= 3'h0;
      sd_s_q   <= 3'h0;
      nrzi_f_q <= 1'b0;
      sd_f_q   <= 1'b0;
    end else begin
      nrzi_s_q <= {nrzi_s_q[1:0], rx_nrzi};
      sd_s_q   <= {sd_s_q[1:0], signal_detect};
      if (nrzi_s_q[1] == nrzi_s_q[2]) nrzi_f_q <= nrzi_s_q[2];
      if (sd_s_q[1] == sd_s_q[2]) sd_f_q <= sd_s_q[2];
    end
  end

  // ****************************************
  // NRZI to NRZ and descrambler
  // ****************************************
  logic        prev_q;
  logic [10:0] lfsr_q;
  logic [10:0] lfsr_d;
  logic        nrz_bit;
  logic        key_bit;
  logic        plain_bit;
  logic        locked_q;
  logic [6:0]  ones_q;
  logic [6:0]  ones_d;
  logic [CNT_W-1:0] unused_w;
  logic [31:0] hold_q;
  logic        hold_exp;
  logic        idle_run_ok;

  assign nrz_bit   = nrzi_f_q ^ prev_q;
  assign key_bit   = lfsr_q[LFSR_TAP_A] ^ lfsr_q[LFSR_TAP_B];
  assign plain_bit = nrz_bit ^ key_bit;
  // Unlocked: load the LFSR from the line assuming idles (ones) were sent
  assign lfsr_d    = {lfsr_q[9:0], locked_q ? key_bit : ~nrz_bit};
  assign ones_d    = plain_bit ? ((ones_q == 7'h7F) ? ones_q : ones_q + 7'h01) : 7'h00;
  // Any idle run of the keep length reloads, so long idle stretches keep the lock
  assign idle_run_ok = (ones_q >= 7'(IDLE_BITS_KEEP - 1)) && plain_bit;
  assign hold_exp    = (hold_q == 32'h0000_0000);
  assign unused_w    = '0;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prev_q   <= 1'b0;
      lfsr_q   <= LFSR_ONES;
      ones_q   <= 7'h00;
      locked_q <= 1'b0;
      hold_q   <= 32'h0000_0000;
    end else begin
      if (rx_bit_en) begin
        prev_q <= nrzi_f_q;
        lfsr_q <= lfsr_d;
        ones_q <= ones_d;
      end
      if (!locked_q) begin
        if (rx_bit_en && ones_q == 7'(SYNC_BITS - 1) && plain_bit) begin
          locked_q <= 1'b1;
          hold_q   <= HOLD_CYCLES;
        end
      end else if (rx_bit_en && idle_run_ok) begin
        hold_q <= HOLD_CYCLES;
      end else if (hold_exp) begin
        locked_q <= 1'b0;
        ones_q   <= 7'h00;
      end else begin
        hold_q <= hold_q - 32'h1;
      end
    end
  end

  // ****************************************
  // Serial to parallel and alignment
  // ****************************************
  logic       aln_bit;
  logic [9:0] sh_q;
  logic [9:0] sh_d;
  logic       aligned_q;
  logic [2:0] ph_q;
  logic       cg_stb;
  logic [4:0] cg;
  logic       jk_hit;
  logic       realign;
  logic       rx_end;
  logic       idle_prev_q;
  rx_state_t  st_q;

  assign aln_bit = descr_bypass ? nrz_bit : plain_bit;
  assign sh_d    = {sh_q[8:0], aln_bit};
  assign jk_hit  = (sh_d == {CG_J, CG_K});
  assign cg      = sh_d[4:0];
  // First zero after a run of ones: frame it as the third bit of a J
  assign realign = !aligned_q && (st_q == RX_IDLE) && (sh_d == {9'h1FF, 1'b0});
  assign cg_stb  = rx_bit_en && (jk_hit || (ph_q == 3'h4 && !realign));

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sh_q      <= 10'h000;
      aligned_q <= 1'b0;
      ph_q      <= 3'h0;
    end else if (rx_bit_en) begin
      sh_q <= sh_d;
      if (jk_hit) begin
        aligned_q <= 1'b1;
        ph_q      <= 3'h0;
      end else if (realign) begin
        ph_q <= 3'h3;
      end else begin
        ph_q <= (ph_q == 3'h4) ? 3'h0 : ph_q + 3'h1;
        if (rx_end && cg_stb) aligned_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Receive state machine
  // ****************************************
  rx_state_t  st_d;
  logic [3:0] tbl_nib;
  logic       tbl_ok;
  logic       t_prev_q;
  logic       is_idle;
  logic       two_idle;
  logic       bad_start_delimiter;
  mii_rx_t    out_d;
  mii_rx_t    out_q;
  logic       en_q;
  logic [CNT_W-1:0] fc_q;
  logic       allow;

  cg_decode u_dec (
    .cg    (cg),
    .nib   (tbl_nib),
    .valid (tbl_ok)
  );

  assign allow    = link_up && (locked_q || descr_bypass);
  assign is_idle  = (cg == CG_IDLE);
  assign two_idle = is_idle && idle_prev_q;
  assign rx_end   = (st_q != RX_IDLE) && (two_idle || (t_prev_q && cg == CG_R));
  // Idle to non-idle that is not the start of a J: J is resolved on next group
  assign bad_start_delimiter  = (st_q == RX_IDLE) && cg_stb && !aligned_q && allow && idle_prev_q &&
                    !is_idle && !jk_hit && cg != CG_J;

  always_comb begin
    st_d  = st_q;
    out_d = out_q;
    if (!allow) begin
      st_d  = RX_IDLE;
      out_d = '0;
    end else begin
      case (st_q)
        RX_IDLE: begin
          out_d = '0;
          if (jk_hit) begin
            st_d  = RX_PACKET;
            out_d = '{dv: 1'b1, er: 1'b0, crs: 1'b1, nib: NIB_PREAM};
          end else if (bad_start_delimiter) begin
            st_d  = RX_BADSSD;
            out_d = '{dv: 1'b0, er: 1'b1, crs: 1'b1, nib: NIB_BADSSD};
          end
        end
        RX_PACKET: begin
          if (rx_end || cg == CG_T) begin
            if (rx_end) st_d = RX_IDLE;
            out_d = '{dv: 1'b0, er: 1'b0, crs: !rx_end, nib: NIB_ZERO};
          end else begin
            out_d = '{dv: 1'b1, er: !tbl_ok, crs: 1'b1, nib: tbl_nib};
          end
        end
        RX_BADSSD: begin
          if (two_idle) begin
            st_d  = RX_IDLE;
            out_d = '0;
          end else begin
            out_d = '{dv: 1'b0, er: 1'b1, crs: 1'b1, nib: NIB_BADSSD};
          end
        end
        default: begin
          st_d  = RX_IDLE;
          out_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_q        <= RX_IDLE;
      out_q       <= '0;
      idle_prev_q <= 1'b0;
      t_prev_q    <= 1'b0;
      en_q        <= 1'b0;
      fc_q        <= '0;
    end else begin
      en_q <= cg_stb && (st_q != RX_IDLE || st_d != RX_IDLE);
      if (cg_stb) begin
        st_q        <= st_d;
        out_q       <= out_d;
        idle_prev_q <= is_idle;
        t_prev_q    <= (cg == CG_T);
        if (st_q == RX_IDLE && st_d == RX_BADSSD && fc_q != CNT_MAX)
          fc_q <= fc_q + 16'h0001;
      end else if (!allow) begin
        st_q  <= RX_IDLE;
        out_q <= '0;
      end
    end
  end

  // ****************************************
  // Link integrity monitor
  // ****************************************
  logic [31:0] link_cnt_q;
  logic        link_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      link_cnt_q <= 32'h0;
      link_q     <= 1'b0;
    end else if (!sd_f_q) begin
      link_cnt_q <= 32'h0;
      link_q     <= 1'b0;
    end else if (link_cnt_q == LINK_CYCLES - 1) begin
      link_q <= 1'b1;
    end else begin
      link_cnt_q <= link_cnt_q + 32'h1;
    end
  end

  assign mii_rx                      = out_q;
  assign mii_rx_en                   = en_q;
  assign descr_locked                = locked_q;
  assign link_up                     = link_q;
  assign false_carrier_event_counter = fc_q | unused_w;

endmodule : rx_pcs_decode

// ==== hw/rx_pcs_pkg.sv ====
package rx_pcs_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_MHZ          = 25;
  localparam int unsigned HOLD_TIME_US     = 722;
  localparam int unsigned HOLD_CYCLES      = HOLD_TIME_US * CLK_MHZ;
  localparam int unsigned LINK_TIME_US     = 395;
  localparam int unsigned LINK_CYCLES      = LINK_TIME_US * CLK_MHZ;
  localparam int unsigned IDLE_BITS_KEEP   = 58;
  localparam int unsigned IDLE_SYNC_GROUPS = 12;
  localparam int unsigned SYNC_BITS        = IDLE_SYNC_GROUPS * 5;

  // ****************************************
  // Code-groups and nibbles
  // ****************************************
  localparam logic [4:0]  CG_IDLE    = 5'h1F;
  localparam logic [4:0]  CG_J       = 5'h18;
  localparam logic [4:0]  CG_K       = 5'h11;
  localparam logic [4:0]  CG_T       = 5'h0D;
  localparam logic [4:0]  CG_R       = 5'h07;
  localparam logic [3:0]  NIB_PREAM  = 4'h5;
  localparam logic [3:0]  NIB_BADSSD = 4'hE;
  localparam logic [3:0]  NIB_ZERO   = 4'h0;
  localparam logic [10:0] LFSR_ONES  = 11'h7FF;
  localparam int unsigned LFSR_TAP_A = 8;
  localparam int unsigned LFSR_TAP_B = 10;
  localparam int unsigned CNT_W      = 16;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;

  // ****************************************
  // Receive stream to the MAC side
  // ****************************************
  typedef struct packed {
    logic       dv;
    logic       er;
    logic       crs;
    logic [3:0] nib;
  } mii_rx_t;

  typedef enum logic [1:0] {
    RX_IDLE   = 2'b00,
    RX_PACKET = 2'b01,
    RX_BADSSD = 2'b10
  } rx_state_t;

endpackage : rx_pcs_pkg

// ==== test/line_model.sv ====
`timescale 1ns/1ps
module line_model (
  // Clock
  input  wire logic core_clk,
  // Serial line
  output logic      rx_nrzi,
  output logic      rx_bit_en
);
  import rx_pcs_pkg::*;
  logic [10:0] lfsr_q = LFSR_ONES;
  logic        scram  = 1'b0;

  initial begin
    rx_nrzi = 1'b0;
    rx_bit_en = 1'b0;
  end

  // One code-group, first bit is bit 4, a bit every second cycle
  task automatic send_cg(input logic [4:0] cg);
    for (int i = 4; i >= 0; i--) begin
      @(negedge core_clk);
      rx_nrzi = rx_nrzi ^ cg[i] ^ (scram & (lfsr_q[10] ^ lfsr_q[8]));
      lfsr_q = {lfsr_q[9:0], lfsr_q[10] ^ lfsr_q[8]};
      rx_bit_en = 1'b1;
      @(negedge core_clk);
      rx_bit_en = 1'b0;
    end
  endtask : send_cg
endmodule : line_model

// ==== test/rx_pcs_sva.sv ====
`timescale 1ns/1ps
module rx_pcs_sva (
  // Clock and reset
  input wire logic                        core_clk,
  input wire logic                        reset,
  // Front end
  input wire logic                        rx_bit_en,
  input wire logic                        signal_detect,
  // Outputs
  input wire rx_pcs_pkg::mii_rx_t         mii_rx,
  input wire logic                        mii_rx_en,
  input wire logic                        descr_locked,
  input wire logic                        link_up,
  input wire logic [rx_pcs_pkg::CNT_W-1:0] false_carrier_event_counter
);
  import rx_pcs_pkg::*;
  int sd_q;
  int bits_q;

  // Cycles of raw signal detect, bit strobes while unlocked
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sd_q <= 0;
      bits_q <= 0;
    end else begin
      sd_q <= signal_detect ? sd_q + 1 : 0;
      bits_q <= descr_locked ? 0 : bits_q + int'(rx_bit_en);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  group_spacing_a: assert property (mii_rx_en && mii_rx.dv |=> !mii_rx_en [*4])
    else $error("code-group strobes closer than five bits");
  no_link_quiet_a: assert property (!link_up [*2] |-> mii_rx == '0 && !mii_rx_en)
    else $error("receive output active without link");
  link_delay_a: assert property ($rose(link_up) |-> sd_q >= LINK_CYCLES)
    else $error("link up before signal detect settled");
  count_step_a: assert property ($changed(false_carrier_event_counter) |->
    false_carrier_event_counter == $past(false_carrier_event_counter) + 16'h0001)
    else $error("false carrier count moved by other than one");
  count_sat_a: assert property (false_carrier_event_counter == CNT_MAX |=>
    false_carrier_event_counter == CNT_MAX)
    else $error("false carrier count wrapped");
  bad_nibble_a: assert property (mii_rx.er && !mii_rx.dv |->
    mii_rx.nib == NIB_BADSSD && mii_rx.crs)
    else $error("bad start nibble or carrier wrong");
  dv_carrier_a: assert property (mii_rx.dv |-> mii_rx.crs)
    else $error("data valid without carrier");
  lock_bits_a: assert property ($rose(descr_locked) |-> bits_q >= SYNC_BITS)
    else $error("descrambler locked too early");
endmodule : rx_pcs_sva

bind rx_pcs_decode rx_pcs_sva u_sva (
  .core_clk(core_clk), .reset(reset), .rx_bit_en(rx_bit_en),
  .signal_detect(signal_detect), .mii_rx(mii_rx), .mii_rx_en(mii_rx_en),
  .descr_locked(descr_locked), .link_up(link_up),
  .false_carrier_event_counter(false_carrier_event_counter));

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import rx_pcs_pkg::*;
  localparam logic [4:0] DCG [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
    5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic             core_clk      = 1'b0;
  logic             reset         = 1'b1;
  logic             signal_detect = 1'b0;
  logic             descr_bypass  = 1'b1;
  logic             rx_nrzi, rx_bit_en, mii_rx_en, descr_locked, link_up;
  mii_rx_t          mii_rx;
  logic [CNT_W-1:0] fc_count;
  int               num_errors  = 0;
  int               comparisons = 0;
  int               cycles      = 0;
  mii_rx_t          seen[$];

  always #20 core_clk = ~core_clk;

  line_model fe (.core_clk(core_clk), .rx_nrzi(rx_nrzi), .rx_bit_en(rx_bit_en));
  rx_pcs_decode uut (.core_clk(core_clk), .reset(reset), .rx_nrzi(rx_nrzi),
    .rx_bit_en(rx_bit_en), .signal_detect(signal_detect), .descr_bypass(descr_bypass),
    .mii_rx(mii_rx), .mii_rx_en(mii_rx_en), .descr_locked(descr_locked),
    .link_up(link_up), .false_carrier_event_counter(fc_count));

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  // Collect data and error nibbles, cut a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (mii_rx_en && (mii_rx.dv || mii_rx.er))
      seen.push_back(mii_rx);
    if (cycles == 70000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic grp(input logic [4:0] cg, input int n = 1);
    repeat (n) fe.send_cg(cg);
  endtask : grp

  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_n

  task automatic t_link;
    check("reset outputs", 16'h0, {6'h00, mii_rx, mii_rx_en, descr_locked, link_up});
    check("reset count", 16'h0, fc_count);
    signal_detect = 1'b1;
    wait_n(5000);
    signal_detect = 1'b0;
    wait_n(10);
    signal_detect = 1'b1;
    wait_n(9500);
    check("link early", 16'h0, link_up);
    wait_n(500);
    check("link up", 16'h1, link_up);
    $display("test link done");
  endtask : t_link

  task automatic t_packet;
    seen.delete();
    grp(CG_IDLE, 4);
    grp(CG_J);
    grp(CG_K);
    for (int i = 0; i < 16; i++)
      grp(DCG[i]);
    grp(CG_T);
    grp(CG_R);
    grp(CG_IDLE, 3);
    check("packet length", 16'd17, seen.size());
    check("preamble", {3'b101, NIB_PREAM}, seen[0]);
    for (int i = 0; i < 16; i++)
      check("data nibble", {3'b101, 4'(i)}, seen[i+1]);
    check("carrier after end", 16'h0, mii_rx.crs);
    $display("test packet done");
  endtask : t_packet

  task automatic t_invalid;
    seen.delete();
    grp(CG_J);
    grp(CG_K);
    grp(DCG[7]);
    grp(CG_J);
    grp(CG_T);
    grp(CG_R);
    grp(CG_IDLE, 3);
    check("control in data", 16'h1, seen[2].er);
    $display("test invalid done");
  endtask : t_invalid

  task automatic t_bad(input logic [15:0] k);
    seen.delete();
    grp(DCG[12], 3);
    grp(CG_IDLE, 4);
    check("bad groups", 16'd4, seen.size());
    foreach (seen[i])
      check("bad nibble", {3'b011, NIB_BADSSD}, seen[i]);
    check("false carrier", k, fc_count);
    check("error carrier drop", 16'h0, {mii_rx.er, mii_rx.crs});
    $display("test bad start done");
  endtask : t_bad

  task automatic t_scramble;
    descr_bypass = 1'b0;
    fe.scram = 1'b1;
    grp(CG_IDLE, 16);
    check("locked", 16'h1, descr_locked);
    seen.delete();
    grp(CG_J);
    grp(CG_K);
    grp(DCG[10]);
    grp(CG_T);
    grp(CG_R);
    grp(CG_IDLE, 2000);
    check("descrambled", 16'h2ADA, {seen[0], seen[1]});
    check("hold kept", 16'h1, descr_locked);
    grp(CG_J);
    grp(CG_K);
    grp(DCG[1], 1900);
    check("lock lost", 16'h0, descr_locked);
    $display("test scramble done");
  endtask : t_scramble

  initial begin
    wait_n(5);
    reset = 1'b0;
    wait_n(1);
    t_link();
    t_packet();
    t_invalid();
    t_bad(16'd1);
    t_bad(16'd2);
    t_scramble();
    close_out();
  end
endmodule : testbench
